// ==== hdl/amb_dev.sv ====
// Converter end: register writes over the serial link, mode selection
// per channel pair and the burst sequencer with its flags.
// Assumes clk_i is the conversion clock; link pins are asynchronous.
//
// The Avalon-MM register port was decided locally.
`include "amb_regs.svh"
module amb_dev import amb_pkg::*; #(
  parameter int CNT_W = 32
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [13:0] conv_ab_i,
  input wire logic [13:0] conv_cd_i,
  output amb_mode_t mode_ab_o,
  output amb_mode_t mode_cd_o,
  amb_link_if.dev link
);
  // Counter must hold the longest low set, 2^31 samples
  if (CNT_W < 31) begin : g_bad_cnt
    $error("amb_dev: CNT_W too small");
  end

  // Index of each asynchronous pin in the synchroniser vector
  localparam int P_SCLK = 0;
  localparam int P_SEN = 1;
  localparam int P_SDAT = 2;
  localparam int P_ENH = 3;
  localparam int P_TRIG = 4;

  // Set length minus one for a power-of-two exponent
  function automatic logic [CNT_W-1:0] amb_len(input logic [4:0] e);
    amb_len = CNT_W'((64'h1 << e) - 64'h1);
  endfunction

  logic [4:0] pin_w; // Raw pins
  logic [4:0] s1_r; // First stage, read only by s2_r
  logic [4:0] s2_r;
  logic [4:0] s3_r;
  logic [4:0] stab_r; // Debounced level
  logic [4:0] stab_nxt;
  logic [4:0] rise_w; // Rising edge of the debounced level
  logic [4:0] agree_w;

  assign pin_w = {link.burst_trigger_input, link.enhancement_enable_pin,
                  link.spi_sdata, link.spi_sen_n, link.spi_sclk};
  assign agree_w = ~(s2_r ^ s3_r);
  // A change counts once the second and third stages agree
  assign stab_nxt = (agree_w & s3_r) | (~agree_w & stab_r);
  // Low one cycle, high the next
  assign rise_w = stab_nxt & ~stab_r;

  // Three-stage synchroniser for all pins
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_r <= 5'h02;
      s2_r <= 5'h02;
      s3_r <= 5'h02;
      stab_r <= 5'h02;
    end else begin
      s1_r <= pin_w;
      s2_r <= s1_r;
      s3_r <= s2_r;
      stab_r <= stab_nxt;
    end
  end

  // Serial receive: frame start, bit shift and frame end
  logic [15:0] sh_r; // Address and data byte
  logic [4:0] bits_r; // Bits taken in this frame
  logic wr_w; // One-cycle register write strobe
  logic sclk_rise_w;
  logic sen_rise_w;
  logic [7:0] wa_w; // Write address
  logic [7:0] wd_w; // Write data

  assign sclk_rise_w = rise_w[P_SCLK] & ~stab_r[P_SEN];
  assign sen_rise_w = rise_w[P_SEN];
  // Only a complete frame writes
  assign wr_w = sen_rise_w & (bits_r == 5'(`AMB_SPI_BITS));
  assign wa_w = sh_r[15:8];
  assign wd_w = sh_r[7:0];

  // Shift on each rising write clock while the frame is open
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sh_r <= 16'h0000;
      bits_r <= 5'h00;
    end else if (sen_rise_w) begin
      bits_r <= 5'h00;
    end else if (sclk_rise_w) begin
      sh_r <= {sh_r[14:0], stab_r[P_SDAT]};
      // Saturate so an overlong frame is rejected
      if (bits_r != 5'h1F) begin
        bits_r <= bits_r + 5'h01;
      end
    end
  end

  // Control registers
  logic auto_r; // Automatic trigger
  logic band45_r; // 45 MHz double band
  logic enh_reg_r; // Register enhancement enable
  logic esrc_r; // Register controls enhancement
  logic ab_sel_r; // Pair AB in burst mode
  logic cd_sel_r; // Pair CD in burst mode
  logic [3:0] hexp_r; // High count exponent as written
  logic [1:0] lrat_r; // Low ratio exponent as written

  // Register writes; all clear to plain 11-bit mode at reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      auto_r <= 1'b0;
      band45_r <= 1'b0;
      enh_reg_r <= 1'b0;
      esrc_r <= 1'b0;
      ab_sel_r <= 1'b0;
      cd_sel_r <= 1'b0;
      hexp_r <= 4'h0;
      lrat_r <= 2'h0;
    end else if (wr_w) begin
      case (wa_w)
        // Trigger source
        `AMB_REG_AUTO: auto_r <= wd_w[`AMB_AUTO_BIT];
        // Band choice
        `AMB_REG_BAND: band45_r <= wd_w[`AMB_BAND_BIT];
        `AMB_REG_ENH: enh_reg_r <= wd_w[`AMB_ENH_BIT];
        `AMB_REG_ESRC: esrc_r <= wd_w[`AMB_ESRC_BIT];
        // Only path into burst mode
        `AMB_REG_PAIR: begin
          ab_sel_r <= wd_w[`AMB_AB_BIT];
          cd_sel_r <= wd_w[`AMB_CD_BIT];
        end
        // Exponents may be written any time
        `AMB_REG_EXP: begin
          hexp_r <= wd_w[`AMB_HEXP_LSB +: 4];
          lrat_r <= wd_w[`AMB_LRAT_LSB +: 2];
        end
        // Other addresses are ignored
        default: ;
      endcase
    end
  end

  // Enhancement source: pin, or register under override
  logic enh_on_w;
  amb_mode_t enh_mode_w;
  assign enh_on_w = esrc_r ? enh_reg_r : stab_r[P_ENH];
  // One band at fs/4 or two at fs/8 and 3fs/8
  assign enh_mode_w = band45_r ? AMB_ENH45 : AMB_ENH90;

  logic [13:0] samp_w [2]; // Output sample of each pair
  logic full_w [2]; // Full-resolution flag of each pair
  logic rdy_w [2]; // Waiting flag of each pair

  // One sequencer per channel pair, each on its own select
  for (genvar g = 0; g < 2; g++) begin : pr
    logic sel_w; // This pair in burst mode
    logic [13:0] conv_w; // This pair's conversion
    amb_burst_st_t st_r;
    amb_burst_st_t st_nxt;
    logic [CNT_W-1:0] cnt_r; // Samples left in set, minus one
    logic [CNT_W-1:0] cnt_nxt;
    logic [3:0] hexp_l_r; // Exponent in force for high sets
    logic latch_w; // Take the written high exponent
    logic [4:0] hi_e_w;
    logic [4:0] lo_e_w;
    amb_mode_t mode_r;
    logic [13:0] data_r;
    logic full_r;
    logic rdy_r;

    assign sel_w = (g == 0) ? ab_sel_r : cd_sel_r;
    assign conv_w = (g == 0) ? conv_ab_i : conv_cd_i;
    // High set length
    assign hi_e_w = 5'(`AMB_HI_BASE) + {1'b0, hexp_l_r};
    // Low set length from exponents taken at high end
    assign lo_e_w = 5'(`AMB_LO_BASE) + {1'b0, hexp_r} + {3'h0, lrat_r};
    // Update outside a burst, or at the end of a high set
    assign latch_w = (st_r == AMB_WAIT) |
                     ((st_r == AMB_HI) & (cnt_r == '0));

    // Next state of the burst sequencer
    always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      case (st_r)
        AMB_WAIT: begin
          // Rising trigger edge starts a high set
          if (rise_w[P_TRIG]) begin
            st_nxt = AMB_HI;
            cnt_nxt = amb_len(hi_e_w);
          end
        end
        AMB_HI: begin
          // Triggers ignored in here
          if (cnt_r == '0) begin
            st_nxt = AMB_LO;
            cnt_nxt = amb_len(lo_e_w);
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
        AMB_LO: begin
          if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
          end else if (auto_r) begin
            // Next high set right after last low sample
            st_nxt = AMB_HI;
            cnt_nxt = amb_len(hi_e_w);
          end else begin
            // Wait for the next manual trigger
            st_nxt = AMB_WAIT;
          end
        end
        default: st_nxt = AMB_WAIT;
      endcase
      // Leaving burst mode drops any set in progress
      if (!sel_w) begin
        st_nxt = AMB_WAIT;
      end
    end

    // Sequencer state, counter and latched exponent
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        st_r <= AMB_WAIT;
        cnt_r <= '0;
        hexp_l_r <= 4'h0;
      end else begin
        st_r <= st_nxt;
        cnt_r <= cnt_nxt;
        if (latch_w) begin
          hexp_l_r <= hexp_r;
        end
      end
    end

    // Output sample and flags, all from flip-flops
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        mode_r <= AMB_PLAIN;
        data_r <= 14'h0000;
        full_r <= 1'b0;
        rdy_r <= 1'b0;
      end else begin
        // Mode per pair
        mode_r <= sel_w ? AMB_BURST : (enh_on_w ? enh_mode_w : AMB_PLAIN);
        // Full word only in a high set, else top eleven bits
        data_r <= (st_r == AMB_HI) ? conv_w : (conv_w & `AMB_LORES_MASK);
        full_r <= (st_r == AMB_HI);
        rdy_r <= sel_w & (st_r == AMB_WAIT);
      end
    end

    assign samp_w[g] = data_r;
    assign full_w[g] = full_r;
    assign rdy_w[g] = rdy_r;
  end

  // Gather both pairs so each link signal has a single driver
  assign link.sample_data = {samp_w[1], samp_w[0]};
  assign link.high_resolution_flag = {full_w[1], full_w[0]};
  assign link.trigger_waiting_flag = {rdy_w[1], rdy_w[0]};
  assign mode_ab_o = pr[0].mode_r;
  assign mode_cd_o = pr[1].mode_r;
endmodule

// ==== hdl/amb_regs.svh ====
// Constants of the mode and burst control: register map, fields, timing.
// Assumes 100 MHz system clock and an SPI-like write link of 16-bit frames.
// Functional notes
// - Reset leaves both pairs in plain 11-bit mode
// - Plain mode sends the eleven top bits
// - Each pair picks its mode independently; here only burst is chosen per pair, enhancement mode is common to both
// - Enhancement from pin, or register when overridden
// - Burst mode enabled only by register bit
// - Register 41h bit 0 selects automatic trigger
// - Register 42h value 4h selects 45 MHz
// - Value 40h in 44h bursts pair AB
// - Value 80h in 44h bursts pair CD
// - Value C0h in 44h bursts both pairs
// - Enhancement band is 90 or two 45 MHz
// - Burst alternates 14-bit and 11-bit sample sets
// - High-resolution flag marks 14-bit samples
// - High-resolution set length is programmable
// - Auto mode restarts right after last low sample
// - Auto mode needs one initial trigger only
// - Manual mode raises trigger-ready flag and waits
// - Manual mode starts each set on rising edge
// - Host writes recommended performance values itself
// - High set holds 2^(10+exponent) samples
// - Low set holds 2^(13+high+ratio) samples
// - New exponents apply at end of high set
// - Trigger edges ignored during a burst cycle
`ifndef AMB_REGS_SVH
`define AMB_REGS_SVH
// Device register offsets and field positions
`define AMB_REG_AUTO 8'h41
`define AMB_AUTO_BIT 0
`define AMB_REG_BAND 8'h42
`define AMB_BAND_BIT 2
`define AMB_REG_ENH 8'h43
`define AMB_ENH_BIT 0
`define AMB_REG_PAIR 8'h44
`define AMB_AB_BIT 6
`define AMB_CD_BIT 7
`define AMB_REG_EXP 8'h45
`define AMB_HEXP_LSB 0
`define AMB_LRAT_LSB 4
`define AMB_REG_ESRC 8'hEA
`define AMB_ESRC_BIT 7
`define AMB_REG_RESET 8'h00
// Burst set sizes, as powers of two
`define AMB_HI_BASE 10
`define AMB_LO_BASE 13
// Keeps the eleven most significant bits of a 14-bit word
`define AMB_LORES_MASK 14'h3FF8
// Write frame: address byte then data byte, MSB first
`define AMB_SPI_BITS 16
// Host register byte offsets on Avalon-MM
`define AMB_AV_CMD 8'h00
`define AMB_AV_PINS 8'h04
`define AMB_AV_STAT 8'h08
`define AMB_AV_SAMP 8'h0C
// Timing
`define AMB_CLK_NS 10
`define AMB_SCLK_NS 160
`define AMB_SCLK_HALF ((`AMB_SCLK_NS / `AMB_CLK_NS) / 2)
`endif

// ==== hdl/amb_pkg.sv ====
// Types shared by both ends of the mode and burst control link.
// Assumes nothing beyond a SystemVerilog compiler.
package amb_pkg;
  // Burst sequencer states, one-hot
  typedef enum logic [2:0] {
    AMB_WAIT = 3'h1,
    AMB_HI = 3'h2,
    AMB_LO = 3'h4
  } amb_burst_st_t;
  // Operating mode of one channel pair, one-hot
  typedef enum logic [3:0] {
    AMB_PLAIN = 4'h1,
    AMB_ENH90 = 4'h2,
    AMB_ENH45 = 4'h4,
    AMB_BURST = 4'h8
  } amb_mode_t;
  // Host write-frame states, one-hot
  typedef enum logic [2:0] {
    AMB_SPI_IDLE = 3'h1,
    AMB_SPI_SHIFT = 3'h2,
    AMB_SPI_END = 3'h4
  } amb_spi_st_t;
endpackage

// ==== hdl/amb_link_if.sv ====
// Pins between the converter control and its host.
// Assumes the bench joins the two modports; all pins are one-way.
interface amb_link_if;
  logic spi_sclk; // Write clock, made by the host
  logic spi_sen_n; // Frame enable, active low
  logic spi_sdata; // Serial write data
  logic enhancement_enable_pin; // Enhancement request pin
  logic burst_trigger_input; // Burst trigger pin
  logic [1:0] high_resolution_flag; // Per pair: 14-bit sample
  logic [1:0] trigger_waiting_flag; // Per pair: waiting for trigger
  logic [1:0][13:0] sample_data; // Per pair output sample
  modport dev (
    input spi_sclk, spi_sen_n, spi_sdata,
    input enhancement_enable_pin, burst_trigger_input,
    output high_resolution_flag, trigger_waiting_flag, sample_data
  );
  modport host (
    output spi_sclk, spi_sen_n, spi_sdata,
    output enhancement_enable_pin, burst_trigger_input,
    input high_resolution_flag, trigger_waiting_flag, sample_data
  );
endinterface

// ==== hdl/amb_host.sv ====
// Host end: Avalon-MM slave with command, pin and status registers,
// serial write master with a divided clock, flag and sample capture.
// Assumes the converter end is on an unrelated clock.
`include "amb_regs.svh"
module amb_host import amb_pkg::*; #(
  parameter int SCLK_HALF = `AMB_SCLK_HALF
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  amb_link_if.host link
);
  if (SCLK_HALF < 2) begin : g_bad_div
    $error("amb_host: SCLK_HALF below 2");
  end

  amb_spi_st_t st_r;
  logic busy_w; // Frame in progress
  logic cmd_hit_w;
  logic pins_hit_w;
  logic rd_ok_r; // Read answer ready
  logic [31:0] rd_mux_w;
  logic [1:0] pins_r; // Trigger and enhancement pin levels
  logic [31:0] in_w; // Raw inputs from the converter
  logic [31:0] s1_r; // First stage, read only by s2_r
  logic [31:0] s2_r;
  logic [31:0] s3_r;
  logic [31:0] stab_r;
  logic [31:0] agree_w;

  assign busy_w = (st_r != AMB_SPI_IDLE);
  assign cmd_hit_w = (avs_address == `AMB_AV_CMD);
  assign pins_hit_w = (avs_address == `AMB_AV_PINS);
  // Reads take one wait cycle; a command waits for a free link
  assign avs_waitrequest = (avs_read & ~rd_ok_r) |
                           (avs_write & cmd_hit_w & busy_w);
  assign in_w = {link.trigger_waiting_flag, link.high_resolution_flag,
                 link.sample_data};
  assign agree_w = ~(s2_r ^ s3_r);
  // Read selection; unmapped reads return zero
  assign rd_mux_w = (avs_address == `AMB_AV_PINS) ? {30'h0, pins_r} :
                    (avs_address == `AMB_AV_STAT) ?
                      {27'h0, stab_r[31:28], busy_w} :
                    (avs_address == `AMB_AV_SAMP) ? {4'h0, stab_r[27:0]} :
                    32'h0;

  // Input synchroniser; a change counts when stages two and three agree
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_r <= 32'h0;
      s2_r <= 32'h0;
      s3_r <= 32'h0;
      stab_r <= 32'h0;
    end else begin
      s1_r <= in_w;
      s2_r <= s1_r;
      s3_r <= s2_r;
      stab_r <= (agree_w & s3_r) | (~agree_w & stab_r);
    end
  end

  // Read answer register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_ok_r <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      rd_ok_r <= avs_read & ~rd_ok_r;
      if (avs_read & ~rd_ok_r) begin
        avs_readdata <= rd_mux_w;
      end
    end
  end

  // Pin levels; trigger edges are made by software toggling
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pins_r <= 2'h0;
    end else if (avs_write & pins_hit_w) begin
      pins_r <= avs_writedata[1:0];
    end
  end

  assign link.enhancement_enable_pin = pins_r[0];
  assign link.burst_trigger_input = pins_r[1];

  // Serial write master; software supplies any performance values
  logic [15:0] sh_r;
  logic [4:0] bits_r;
  logic [$clog2(SCLK_HALF+1)-1:0] div_r;
  logic tick_w; // Half-period enable
  logic sclk_r;
  logic sen_n_r;

  assign tick_w = (div_r == ($bits(div_r))'(SCLK_HALF - 1));

  // Frame sequencer: data changes on falling clock, held for rising
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= AMB_SPI_IDLE;
      sh_r <= 16'h0;
      bits_r <= 5'h0;
      div_r <= '0;
      sclk_r <= 1'b0;
      sen_n_r <= 1'b1;
    end else begin
      div_r <= tick_w ? '0 : div_r + 1'b1;
      case (st_r)
        AMB_SPI_IDLE: begin
          div_r <= '0;
          // Any 16-bit command (address, data) e.g. 42h/04h
          if (avs_write & cmd_hit_w) begin
            sh_r <= avs_writedata[15:0];
            bits_r <= 5'h0;
            sen_n_r <= 1'b0;
            st_r <= AMB_SPI_SHIFT;
          end
        end
        AMB_SPI_SHIFT: begin
          if (tick_w) begin
            sclk_r <= ~sclk_r;
            if (sclk_r) begin
              if (bits_r == 5'(`AMB_SPI_BITS)) begin
                sen_n_r <= 1'b1;
                st_r <= AMB_SPI_END;
              end else begin
                sh_r <= {sh_r[14:0], 1'b0};
              end
            end else begin
              bits_r <= bits_r + 5'h1;
            end
          end
        end
        AMB_SPI_END: begin
          // Idle gap so the far end sees the frame close
          sclk_r <= 1'b0;
          if (tick_w) begin
            st_r <= AMB_SPI_IDLE;
          end
        end
        default: st_r <= AMB_SPI_IDLE;
      endcase
    end
  end

  assign link.spi_sclk = sclk_r;
  assign link.spi_sen_n = sen_n_r;
  assign link.spi_sdata = sh_r[15];
endmodule

// ==== test/amb_chk.sv ====
// Checker for the link between the converter end and its host end.
// Assumes both ends share clk_i; instanced beside the link interface.
module amb_chk #(
  parameter int SCLK_HALF = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic spi_sclk,
  input wire logic spi_sen_n,
  input wire logic spi_sdata,
  input wire logic enhancement_enable_pin,
  input wire logic burst_trigger_input,
  input wire logic [1:0] high_resolution_flag,
  input wire logic [1:0] trigger_waiting_flag,
  input wire logic [1:0][13:0] sample_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  int hi_cnt; // Cycles in the current AB high set
  int lo_cnt; // Cycles since the AB high set ended
  int sc_cnt; // Cycles the write clock has been high
  int bit_cnt; // Write clock rises within this frame
  logic fell_seen; // An AB high set has ended since reset
  // Run-length counters behind the count checks
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_cnt <= 0;
      lo_cnt <= 0;
      sc_cnt <= 0;
      bit_cnt <= 0;
      fell_seen <= 1'b0;
    end else begin
      hi_cnt <= high_resolution_flag[0] ? hi_cnt + 1 : 0;
      lo_cnt <= high_resolution_flag[0] ? 0 : lo_cnt + 1;
      sc_cnt <= spi_sclk ? sc_cnt + 1 : 0;
      bit_cnt <= spi_sen_n ? 0 : bit_cnt + int'(spi_sclk && sc_cnt == 0);
      fell_seen <= fell_seen | (hi_cnt != 0 && !high_resolution_flag[0]);
    end
  end
  AST_AB_EXCL: assert property (
    high_resolution_flag[0] |-> !trigger_waiting_flag[0])
    else $error("AB full and waiting flags both high");
  AST_CD_EXCL: assert property (
    high_resolution_flag[1] |-> !trigger_waiting_flag[1])
    else $error("CD full and waiting flags both high");
  AST_AB_LORES: assert property (
    !high_resolution_flag[0] |-> sample_data[0][2:0] == 3'h0)
    else $error("AB short sample has low bits set");
  AST_CD_LORES: assert property (
    !high_resolution_flag[1] |-> sample_data[1][2:0] == 3'h0)
    else $error("CD short sample has low bits set");
  AST_HI_LEN: assert property (
    $fell(high_resolution_flag[0]) |->
      hi_cnt >= 1024 && (hi_cnt & (hi_cnt - 1)) == 0)
    else $error("AB full set length wrong");
  AST_LO_MIN: assert property (
    $rose(high_resolution_flag[0]) && fell_seen |-> lo_cnt >= 8192)
    else $error("AB short set too short");
  AST_EDGE_START: assert property (
    $rose(burst_trigger_input) && trigger_waiting_flag[0] |->
      ##[2:10] high_resolution_flag[0])
    else $error("AB full set not started by edge");
  AST_SCLK_HALF: assert property (
    $fell(spi_sclk) |-> sc_cnt == SCLK_HALF)
    else $error("Write clock high time wrong");
  AST_SDATA_HOLD: assert property (
    spi_sclk |-> $stable(spi_sdata))
    else $error("Write data moved while clock high");
  AST_FRAME_BITS: assert property (
    $rose(spi_sen_n) |-> bit_cnt == 16)
    else $error("Write frame not sixteen bits");
endmodule

// ==== test/adc_mode_burst_control_tb.sv ====
// Bench joining converter end and host end; software side is driven.
// Assumes one 100 MHz clock for both ends and a host write-clock half period of 4 clocks.
`include "amb_regs.svh"
module adc_mode_burst_control_tb
  import amb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, nrst_i; // Clock and active-low reset
  logic [7:0] avs_address; // Avalon request
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic [13:0] conv_ab, conv_cd; // Conversion words
  amb_mode_t mode_ab, mode_cd; // Pair modes seen
  logic hf, hprev; // AB full-resolution flag and its last value
  int failures, n_tests, run, n_rise;
  int len[2]; // Last run length of the AB flag, low and high
  amb_link_if amb_link_if_i();
  amb_dev amb_dev_i (.clk_i(clk_i), .nrst_i(nrst_i), .conv_ab_i(conv_ab),
    .conv_cd_i(conv_cd), .mode_ab_o(mode_ab), .mode_cd_o(mode_cd),
    .link(amb_link_if_i.dev));
  amb_host #(.SCLK_HALF(4)) amb_host_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .link(amb_link_if_i.host));
  amb_chk #(.SCLK_HALF(4)) amb_chk_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .spi_sclk(amb_link_if_i.spi_sclk), .spi_sen_n(amb_link_if_i.spi_sen_n),
    .spi_sdata(amb_link_if_i.spi_sdata),
    .enhancement_enable_pin(amb_link_if_i.enhancement_enable_pin),
    .burst_trigger_input(amb_link_if_i.burst_trigger_input),
    .high_resolution_flag(amb_link_if_i.high_resolution_flag),
    .trigger_waiting_flag(amb_link_if_i.trigger_waiting_flag),
    .sample_data(amb_link_if_i.sample_data));
  assign hf = amb_link_if_i.high_resolution_flag[0];
  // Clock source
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Measures run lengths of the AB flag and counts its rises
  always @(posedge clk_i) begin
    hprev <= hf;
    if (hf !== hprev) begin
      len[hprev] <= run;
      run <= 1;
      n_rise <= n_rise + int'(hf);
    end else begin
      run <= run + 1;
    end
  end
  // Prints counts and verdict, then stops
  task end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Compares a seen value against the expected one
  task chk(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task av(input logic wr, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] r);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk_i);
    while (avs_waitrequest !== 1'b0 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_i);
    chk("av_done", {31'h0, n >= 1000}, 32'h0);
  endtask
  // Device register write through the command register
  task regw(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    int n;
    n = 0;
    av(1'b1, `AMB_AV_CMD, {16'h0, a, d}, r);
    r = 32'h1;
    while (r[0] !== 1'b0 && n < 200) begin
      av(1'b0, `AMB_AV_STAT, 32'h0, r);
      n++;
    end
    repeat (12) @(posedge clk_i);
  endtask
  // Sets the pin outputs of the host
  task pins(input logic [31:0] v);
    logic [31:0] r;
    av(1'b1, `AMB_AV_PINS, v, r);
  endtask
  // Pulse on the burst trigger pin
  task pulse();
    pins(32'h2);
    repeat (8) @(posedge clk_i);
    pins(32'h0);
  endtask
  // Waits for the AB full flag or waiting flag to reach a level
  task wait_sig(input logic rdy, input logic v, input int lim);
    int n;
    n = 0;
    while ((rdy ? amb_link_if_i.trigger_waiting_flag[0] : hf) !== v
           && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk("flag_wait", {31'h0, n >= lim}, 32'h0);
    @(posedge clk_i);
  endtask
  // Pin level, one register write, then both pair modes
  task step(input logic pin, input logic [7:0] a, d,
            input amb_mode_t eab, ecd);
    pins({31'h0, pin});
    regw(a, d);
    chk("mode_ab", {28'h0, mode_ab}, {28'h0, eab});
    chk("mode_cd", {28'h0, mode_cd}, {28'h0, ecd});
  endtask
  // State after reset, plain output, status and unmapped read
  task t_reset();
    logic [31:0] r;
    chk("mode_ab", {28'h0, mode_ab}, {28'h0, AMB_PLAIN});
    chk("mode_cd", {28'h0, mode_cd}, {28'h0, AMB_PLAIN});
    chk("samp_cd", {18'h0, amb_link_if_i.sample_data[1]}, 32'h2A50);
    av(1'b0, `AMB_AV_STAT, 32'h0, r);
    chk("status", {27'h0, r[4:0]}, 32'h0);
    av(1'b0, 8'h10, 32'h0, r);
    chk("unmapped", r, 32'h0);
    av(1'b0, `AMB_AV_SAMP, 32'h0, r);
    chk("samples", r, 32'h0A941FF8);
  endtask
  // Eleven mode steps over pin, band, override, enable and pair selects
  task t_modes();
    step(1'b1, 8'h42, 8'h04, AMB_ENH45, AMB_ENH45);
    step(1'b1, 8'h42, 8'h00, AMB_ENH90, AMB_ENH90);
    step(1'b1, 8'h44, 8'h40, AMB_BURST, AMB_ENH90);
    step(1'b1, 8'h44, 8'h80, AMB_ENH90, AMB_BURST);
    step(1'b0, 8'h44, 8'hC0, AMB_BURST, AMB_BURST);
    step(1'b1, 8'h44, 8'h00, AMB_ENH90, AMB_ENH90);
    step(1'b1, 8'hEA, 8'h80, AMB_PLAIN, AMB_PLAIN);
    step(1'b0, 8'h43, 8'h01, AMB_ENH90, AMB_ENH90);
    step(1'b0, 8'hEA, 8'h00, AMB_PLAIN, AMB_PLAIN);
    step(1'b0, 8'h43, 8'h00, AMB_PLAIN, AMB_PLAIN);
    step(1'b0, 8'hD6, 8'h80, AMB_PLAIN, AMB_PLAIN);
  endtask
  // Manual bursts: waiting flag, full set length, ignored edge, re-arm
  task t_manual();
    logic [31:0] r;
    int r0;
    regw(8'h45, 8'h00);
    regw(8'h41, 8'h00);
    regw(8'h44, 8'h40);
    wait_sig(1'b1, 1'b1, 200);
    av(1'b0, `AMB_AV_STAT, 32'h0, r);
    chk("ab_ready", {31'h0, r[3]}, 32'h1);
    chk("cd_ready", {31'h0, r[4]}, 32'h0);
    r0 = n_rise;
    pulse();
    wait_sig(1'b0, 1'b1, 100);
    chk("full_data", {18'h0, amb_link_if_i.sample_data[0]}, 32'h1FFF);
    chk("cd_full", {31'h0, amb_link_if_i.high_resolution_flag[1]}, 0);
    wait_sig(1'b0, 1'b0, 2000);
    chk("full_len", len[1], 32'd1024);
    chk("low_data", {18'h0, amb_link_if_i.sample_data[0]}, 32'h1FF8);
    pulse();
    wait_sig(1'b1, 1'b1, 10000);
    chk("ignored", n_rise - r0, 32'd1);
    pulse();
    wait_sig(1'b0, 1'b1, 100);
    chk("rearm", n_rise - r0, 32'd2);
    wait_sig(1'b1, 1'b1, 10000);
  endtask
  // Auto bursts: one edge, late exponent change, back-to-back sets
  task t_auto();
    regw(8'h41, 8'h01);
    pulse();
    wait_sig(1'b0, 1'b1, 100);
    regw(8'h45, 8'h01);
    wait_sig(1'b0, 1'b0, 2000);
    chk("full_len", len[1], 32'd1024);
    wait_sig(1'b0, 1'b1, 20000);
    chk("short_len", len[0], 32'd16384);
    wait_sig(1'b0, 1'b0, 3000);
    chk("full_len2", len[1], 32'd2048);
    regw(8'h44, 8'h00);
    chk("mode_ab", {28'h0, mode_ab}, {28'h0, AMB_PLAIN});
  endtask
  // Main sequence
  initial begin
    nrst_i = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    conv_ab = 14'h1FFF;
    conv_cd = 14'h2A57;
    failures = 0;
    n_tests = 0;
    run = 0;
    n_rise = 0;
    hprev = 1'b0;
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_modes();
    t_manual();
    t_auto();
    end_sim();
  end
  // Cuts a hang short
  initial begin
    #800000;
    failures++;
    end_sim();
  end
endmodule
